/* File: rtl/hw_powerdown_sequencer.sv */
`timescale 1ns/1ns
module hw_powerdown_sequencer #(
  parameter int unsigned MC_CYCLES = pseq_pkg::MC_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hw_powerdown_n,
  input  wire logic        reset_pin_n,
  input  wire logic        osc_watchdog_enable_pin,
  input  wire logic        powersave_enable_autowdt_pin,
  input  wire logic        boot_program_enable_pin,
  input  wire logic        main_osc_running,
  input  wire logic        wdt_overflow,
  input  wire logic        osc_status_clr,
  input  wire logic [15:0] code_addr,
  output logic             port_oe_n,
  output logic             port_input_en,
  output logic             strobe_oe_n,
  output logic             powersave_pullup_en,
  output logic             owe_pullup_en,
  output logic             main_osc_en,
  output logic             rc_osc_en,
  output logic             internal_reset,
  output logic             osc_fail_flag,
  output logic             osc_status_flag,
  output logic             wdt_run,
  output logic             wdt_reload,
  output logic             wdt_status_flag,
  output logic             bootstrap_mode_flag,
  output logic             boot_rom_select,
  output logic             sw_powersave_allowed,
  output logic             autowdt_strap,
  output logic             in_hw_powerdown,
  output logic             clk_sel_main,
  output logic             main_clk_gate,
  output logic             rc_clk_gate
);

  localparam int unsigned MW = (MC_CYCLES < 2) ? 1 : $clog2(MC_CYCLES);
  localparam int unsigned RW = (pseq_pkg::RST_MCS < 2) ? 1 : $clog2(pseq_pkg::RST_MCS);

  generate
    if (MC_CYCLES < 1) begin : g_chk
      $error("hw_powerdown_sequencer: MC_CYCLES must be at least 1");
    end
  endgenerate

  pseq_pkg::seq_state_t state_q;
  logic [MW-1:0]        mc_cnt_q;
  logic                 mc_tick;
  logic [RW-1:0]        rst_cnt_q;
  logic                 rst_done;
  logic                 reset_pin_prev_q;
  logic                 por_pending_q;
  logic                 restart_ev;
  logic                 ext_release_ev;
  logic                 pd_release_ev;

  clk_sel_if sel ();

  // machine cycle timebase; power-down pin sampling and the reset count hang off its tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt_q <= '0;
    end else if (ce) begin
      if (mc_tick) begin
        mc_cnt_q <= '0;
      end else begin
        mc_cnt_q <= mc_cnt_q + MW'(1);
      end
    end
  end

  assign mc_tick  = (mc_cnt_q == MW'(MC_CYCLES - 1));
  assign rst_done = mc_tick && (rst_cnt_q == RW'(pseq_pkg::RST_MCS - 1));

  // events that leave a reset or power-down state this cycle
  assign ext_release_ev = (state_q == pseq_pkg::ST_EXT_RST) && reset_pin_n;
  assign pd_release_ev  = (state_q == pseq_pkg::ST_PD) && mc_tick && hw_powerdown_n
                          && reset_pin_n;
  assign restart_ev     = (state_q == pseq_pkg::ST_FINAL_RST) && rst_done && reset_pin_n;

  // sequencer; the reset pin beats everything, including power down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= pseq_pkg::ST_EXT_RST;
      rst_cnt_q <= '0;
    end else if (ce) begin
      if (!reset_pin_n) begin
        state_q <= pseq_pkg::ST_EXT_RST;
      end else begin
        unique case (state_q)
          pseq_pkg::ST_RUN: begin
            if (mc_tick && !hw_powerdown_n) begin
              state_q   <= pseq_pkg::ST_RST_SEQ;
              rst_cnt_q <= '0;
            end else if (!main_osc_running) begin
              state_q <= pseq_pkg::ST_WAIT_OSC;
            end
          end
          pseq_pkg::ST_RST_SEQ: begin
            if (rst_done) begin
              // a pin seen low only once gives a plain reset and a return to run
              state_q <= hw_powerdown_n ? pseq_pkg::ST_RUN : pseq_pkg::ST_PD;
            end else if (mc_tick) begin
              rst_cnt_q <= rst_cnt_q + RW'(1);
            end
          end
          pseq_pkg::ST_PD: begin
            // the model keeps ticking here; real silicon has no clock in this state
            if (pd_release_ev) begin
              state_q <= pseq_pkg::ST_WAIT_OSC;
            end
          end
          pseq_pkg::ST_WAIT_OSC: begin
            // with the watchdog-enable pin low no oscillator starts: stuck by design
            if (osc_watchdog_enable_pin && main_osc_running) begin
              state_q   <= pseq_pkg::ST_FINAL_RST;
              rst_cnt_q <= '0;
            end
          end
          pseq_pkg::ST_FINAL_RST: begin
            if (!main_osc_running) begin
              state_q <= pseq_pkg::ST_WAIT_OSC;
            end else if (rst_done) begin
              state_q <= pseq_pkg::ST_RUN;
            end else if (mc_tick) begin
              rst_cnt_q <= rst_cnt_q + RW'(1);
            end
          end
          pseq_pkg::ST_EXT_RST: begin
            state_q <= main_osc_running ? pseq_pkg::ST_RUN : pseq_pkg::ST_WAIT_OSC;
          end
          default: begin
            state_q <= pseq_pkg::ST_EXT_RST;
          end
        endcase
      end
    end
  end

  // pin and oscillator control follows the state one clock later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_oe_n           <= 1'b0;
      port_input_en       <= 1'b1;
      strobe_oe_n         <= 1'b0;
      powersave_pullup_en <= 1'b1;
      owe_pullup_en       <= 1'b1;
      main_osc_en         <= 1'b1;
      rc_osc_en           <= 1'b1;
      internal_reset      <= 1'b1;
      osc_fail_flag       <= 1'b0;
      in_hw_powerdown     <= 1'b0;
    end else if (ce) begin
      in_hw_powerdown     <= (state_q == pseq_pkg::ST_PD);
      port_oe_n           <= (state_q == pseq_pkg::ST_PD);
      port_input_en       <= (state_q != pseq_pkg::ST_PD);
      strobe_oe_n         <= (state_q == pseq_pkg::ST_PD);
      powersave_pullup_en <= (state_q != pseq_pkg::ST_PD);
      owe_pullup_en       <= (state_q != pseq_pkg::ST_PD);
      unique case (state_q)
        pseq_pkg::ST_PD: begin
          main_osc_en <= 1'b0;
          rc_osc_en   <= 1'b0;
        end
        pseq_pkg::ST_WAIT_OSC, pseq_pkg::ST_FINAL_RST: begin
          main_osc_en <= osc_watchdog_enable_pin;
          rc_osc_en   <= osc_watchdog_enable_pin;
        end
        default: begin
          main_osc_en <= 1'b1;
          rc_osc_en   <= osc_watchdog_enable_pin;
        end
      endcase
      internal_reset <= (state_q != pseq_pkg::ST_RUN);
      osc_fail_flag  <= (state_q == pseq_pkg::ST_WAIT_OSC);
    end
  end

  // glitch-free source change: rc while waiting for the crystal or powered down, main otherwise
  assign sel.req_main = (state_q != pseq_pkg::ST_WAIT_OSC) && (state_q != pseq_pkg::ST_PD);

  clock_switch #(
    .GAP (pseq_pkg::SWITCH_GAP)
  ) u_clock_switch (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .sel   (sel.sw)
  );

  // mirror the switch state onto top-level flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_main  <= 1'b0;
      main_clk_gate <= 1'b0;
      rc_clk_gate   <= 1'b1;
    end else if (ce) begin
      clk_sel_main  <= sel.sel_main;
      main_clk_gate <= sel.main_gate;
      rc_clk_gate   <= sel.rc_gate;
    end
  end

  // autostart strap: caught only in the first cycle after power-on or while
  // the reset pin is held; a power-down reset does not re-read it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      por_pending_q    <= 1'b1;
      autowdt_strap    <= pseq_pkg::STRAP_RST;
      reset_pin_prev_q <= 1'b1;
    end else if (ce) begin
      por_pending_q    <= 1'b0;
      reset_pin_prev_q <= reset_pin_n;
      if (por_pending_q || !reset_pin_n) begin
        autowdt_strap <= powersave_enable_autowdt_pin;
      end
    end
  end

  // software saving modes only with the powersave pin low, never in power down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_powersave_allowed <= 1'b0;
    end else if (ce) begin
      sw_powersave_allowed <= !powersave_enable_autowdt_pin
                              && (state_q == pseq_pkg::ST_RUN);
    end
  end

  // watchdog timer run and status; any internal reset stops it, only the reset sequence and the reset pin clear the status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdt_run         <= 1'b0;
      wdt_reload      <= 1'b0;
      wdt_status_flag <= 1'b0;
    end else if (ce) begin
      wdt_reload <= 1'b0;
      if ((restart_ev || ext_release_ev) && autowdt_strap) begin
        wdt_run    <= 1'b1;
        wdt_reload <= 1'b1;
      end else if (state_q != pseq_pkg::ST_RUN) begin
        wdt_run <= 1'b0;
      end
      if (wdt_overflow && wdt_run) begin
        wdt_status_flag <= 1'b1;
      end else if (state_q == pseq_pkg::ST_RST_SEQ || state_q == pseq_pkg::ST_EXT_RST) begin
        wdt_status_flag <= 1'b0;
      end
    end
  end

  // oscillator watchdog status: set on every recovery, set wins over clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_status_flag <= 1'b0;
    end else if (ce) begin
      if (restart_ev) begin
        osc_status_flag <= 1'b1;
      end else if (osc_status_clr) begin
        osc_status_flag <= 1'b0;
      end
    end
  end

  // bootstrap mode taken at the rising edge of the reset pin or on release from power down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bootstrap_mode_flag <= pseq_pkg::BOOT_FLAG_RST;
    end else if (ce) begin
      if ((reset_pin_n && !reset_pin_prev_q) || pd_release_ev) begin
        bootstrap_mode_flag <= boot_program_enable_pin;
      end
    end
  end

  // boot rom overlay decode, registered for a clean select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_rom_select <= 1'b0;
    end else if (ce) begin
      boot_rom_select <= bootstrap_mode_flag
                         && (code_addr >= pseq_pkg::BOOT_ROM_LO)
                         && (code_addr <= pseq_pkg::BOOT_ROM_HI);
    end
  end

endmodule

/* File: rtl/hw_powerdown_n_pkg.sv */
package pseq_pkg;

  // machine cycle length in clock periods, used as the default
  localparam int unsigned MC_CYCLES_DEF = 12;
  // internal reset length in machine cycles
  localparam int unsigned RST_MCS       = 2;
  // dead clocks with both clock gates shut during a switch-over
  localparam int unsigned SWITCH_GAP    = 2;

  // boot rom window over the lowest code addresses
  localparam logic [15:0] BOOT_ROM_LO   = 16'h0000;
  localparam logic [15:0] BOOT_ROM_HI   = 16'h01FF;

  // values after reset
  localparam logic        BOOT_FLAG_RST = 1'b0;
  localparam logic        STRAP_RST     = 1'b0;

  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_RST_SEQ   = 3'b001,
    ST_PD        = 3'b010,
    ST_WAIT_OSC  = 3'b011,
    ST_FINAL_RST = 3'b100,
    ST_EXT_RST   = 3'b101
  } seq_state_t;

endpackage

/* File: rtl/clk_sel_if.sv */
`timescale 1ns/1ns
interface clk_sel_if;
  logic req_main;
  logic sel_main;
  logic main_gate;
  logic rc_gate;

  modport ctrl (output req_main, input sel_main, input main_gate, input rc_gate);
  modport sw   (input req_main, output sel_main, output main_gate, output rc_gate);
endinterface

/* File: rtl/clock_switch.sv */
`timescale 1ns/1ns
module clock_switch #(
  parameter int unsigned GAP = pseq_pkg::SWITCH_GAP
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  clk_sel_if.sw     sel
);

  localparam int unsigned GW = (GAP < 2) ? 1 : $clog2(GAP + 1);

  logic [GW-1:0] gap_q;
  logic          busy_q;

  generate
    if (GAP < 1) begin : g_chk
      $error("clock_switch: GAP must be at least 1");
    end
  endgenerate

  // break-before-make: both gates shut for GAP clocks, so no runt pulse
  // can reach the core while the source changes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel.sel_main  <= 1'b0;
      sel.main_gate <= 1'b0;
      sel.rc_gate   <= 1'b1;
      busy_q        <= 1'b0;
      gap_q         <= '0;
    end else if (ce) begin
      if (!busy_q && (sel.req_main != sel.sel_main)) begin
        sel.main_gate <= 1'b0;
        sel.rc_gate   <= 1'b0;
        busy_q        <= 1'b1;
        gap_q         <= '0;
      end else if (busy_q) begin
        if (gap_q == GW'(GAP - 1)) begin
          busy_q        <= 1'b0;
          sel.sel_main  <= sel.req_main;
          sel.main_gate <= sel.req_main;
          sel.rc_gate   <= !sel.req_main;
        end else begin
          gap_q <= gap_q + GW'(1);
        end
      end
    end
  end

endmodule

/* File: verif/hw_powerdown_n_sva.sv */
`timescale 1ns/1ns
module pseq_sva #(
  parameter int unsigned MC_CYCLES = 12
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hw_powerdown_n,
  input wire logic reset_pin_n,
  input wire logic port_oe_n,
  input wire logic port_input_en,
  input wire logic strobe_oe_n,
  input wire logic powersave_pullup_en,
  input wire logic owe_pullup_en,
  input wire logic main_osc_en,
  input wire logic rc_osc_en,
  input wire logic internal_reset,
  input wire logic wdt_run,
  input wire logic wdt_reload,
  input wire logic wdt_status_flag,
  input wire logic autowdt_strap,
  input wire logic in_hw_powerdown,
  input wire logic main_clk_gate,
  input wire logic rc_clk_gate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // pin, oscillator, reset and watchdog states while powered down
  property p_float; in_hw_powerdown |-> port_oe_n && strobe_oe_n && !port_input_en; endproperty
  property p_pull; in_hw_powerdown |-> !powersave_pullup_en && !owe_pullup_en; endproperty
  property p_osc_off; in_hw_powerdown |-> !main_osc_en && !rc_osc_en; endproperty
  property p_rst_pd; in_hw_powerdown |-> internal_reset && !wdt_run && !wdt_status_flag; endproperty
  // a low pin with reset idle keeps the part down; outputs lag the state by a clock
  property p_hold;
    in_hw_powerdown && $past(!hw_powerdown_n) && $past(reset_pin_n) |=> in_hw_powerdown;
  endproperty
  property p_leave; $fell(in_hw_powerdown) |-> !port_oe_n && internal_reset; endproperty
  property p_ext; $fell(reset_pin_n) |-> ##2 (internal_reset && !in_hw_powerdown); endproperty
  // both gates open at once would glitch the internal clock
  property p_gates; !(main_clk_gate && rc_clk_gate); endproperty
  property p_reload; wdt_reload |-> wdt_run && autowdt_strap ##1 !wdt_reload; endproperty

  a_float: assert property (p_float) else $error("pins driven in power down");
  a_pull: assert property (p_pull) else $error("pull-up on in power down");
  a_osc_off: assert property (p_osc_off) else $error("oscillator on in power down");
  a_rst_pd: assert property (p_rst_pd) else $error("watchdog alive in power down");
  a_hold: assert property (p_hold) else $error("left power down with pin low");
  a_leave: assert property (p_leave) else $error("bad pin state on restart");
  a_ext: assert property (p_ext) else $error("reset pin not obeyed");
  a_gates: assert property (p_gates) else $error("both clock gates open");
  a_reload: assert property (p_reload) else $error("bad watchdog reload pulse");

  // main scenarios reached
  c_pd: cover property (in_hw_powerdown ##1 !in_hw_powerdown);
  c_reload: cover property (wdt_reload);
  c_ext: cover property (in_hw_powerdown ##1 !reset_pin_n);
endmodule

bind hw_powerdown_sequencer pseq_sva #(.MC_CYCLES(MC_CYCLES)) u_sva (
  .clock, .rst_n, .hw_powerdown_n, .reset_pin_n, .port_oe_n, .port_input_en,
  .strobe_oe_n, .powersave_pullup_en, .owe_pullup_en, .main_osc_en, .rc_osc_en,
  .internal_reset, .wdt_run, .wdt_reload, .wdt_status_flag, .autowdt_strap,
  .in_hw_powerdown, .main_clk_gate, .rc_clk_gate
);

/* File: verif/power_supervisor_model.sv */
`timescale 1ns/1ns
module power_supervisor_model #(
  parameter int unsigned START = 20
) (
  input  wire logic clock,
  input  wire logic main_osc_en,
  output logic      hw_powerdown_n,
  output logic      reset_pin_n,
  output logic      osc_watchdog_enable_pin,
  output logic      main_osc_running
);
  int unsigned run_cnt = 0;

  // idle levels: reset kept inactive and the enable strap high
  initial begin
    hw_powerdown_n          = 1'b1;
    reset_pin_n             = 1'b1;
    osc_watchdog_enable_pin = 1'b1;
    main_osc_running        = 1'b0;
  end

  // all pins change together just after an edge, never mid-cycle
  task automatic set(input logic pd, input logic rp, input logic ow);
    @(posedge clock);
    #1;
    hw_powerdown_n          = pd;
    reset_pin_n             = rp;
    osc_watchdog_enable_pin = ow;
  endtask

  // crystal needs START clocks to build up and stops at once when disabled
  always @(posedge clock) begin
    run_cnt          <= main_osc_en ? run_cnt + 1 : 0;
    main_osc_running <= #1 main_osc_en && (run_cnt >= START);
  end
endmodule

/* File: verif/hw_powerdown_sequencer_tb.sv */
`timescale 1ns/1ns
module hw_powerdown_sequencer_tb;
  localparam int MC = 3;
  logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1, pd_seen = 1'b0;
  logic        powersave_enable_autowdt_pin = 1'b1, boot_program_enable_pin = 1'b0;
  logic        wdt_overflow = 1'b0, osc_status_clr = 1'b0;
  logic [15:0] code_addr = 16'h0000;
  logic        hw_powerdown_n, reset_pin_n, osc_watchdog_enable_pin, main_osc_running;
  logic        port_oe_n, port_input_en, strobe_oe_n, powersave_pullup_en, owe_pullup_en;
  logic        main_osc_en, rc_osc_en, internal_reset, osc_fail_flag, osc_status_flag;
  logic        wdt_run, wdt_reload, wdt_status_flag, bootstrap_mode_flag, boot_rom_select;
  logic        sw_powersave_allowed, autowdt_strap, in_hw_powerdown, clk_sel_main;
  logic        main_clk_gate, rc_clk_gate;
  int          error_cnt = 0, n_tests = 0, n_reload = 0;

  // device and supervisor share the bench nets
  hw_powerdown_sequencer #(.MC_CYCLES(MC)) uut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .hw_powerdown_n(hw_powerdown_n),
    .reset_pin_n(reset_pin_n), .osc_watchdog_enable_pin(osc_watchdog_enable_pin),
    .powersave_enable_autowdt_pin(powersave_enable_autowdt_pin),
    .boot_program_enable_pin(boot_program_enable_pin), .main_osc_running(main_osc_running),
    .wdt_overflow(wdt_overflow), .osc_status_clr(osc_status_clr), .code_addr(code_addr),
    .port_oe_n(port_oe_n), .port_input_en(port_input_en), .strobe_oe_n(strobe_oe_n),
    .powersave_pullup_en(powersave_pullup_en), .owe_pullup_en(owe_pullup_en),
    .main_osc_en(main_osc_en), .rc_osc_en(rc_osc_en), .internal_reset(internal_reset),
    .osc_fail_flag(osc_fail_flag), .osc_status_flag(osc_status_flag), .wdt_run(wdt_run),
    .wdt_reload(wdt_reload), .wdt_status_flag(wdt_status_flag),
    .bootstrap_mode_flag(bootstrap_mode_flag), .boot_rom_select(boot_rom_select),
    .sw_powersave_allowed(sw_powersave_allowed), .autowdt_strap(autowdt_strap),
    .in_hw_powerdown(in_hw_powerdown), .clk_sel_main(clk_sel_main),
    .main_clk_gate(main_clk_gate), .rc_clk_gate(rc_clk_gate)
  );
  power_supervisor_model sup (
    .clock(clock), .main_osc_en(main_osc_en), .hw_powerdown_n(hw_powerdown_n),
    .reset_pin_n(reset_pin_n), .osc_watchdog_enable_pin(osc_watchdog_enable_pin),
    .main_osc_running(main_osc_running)
  );

  always #10 clock = ~clock;
  // remembers any visit to power down, for the short-pulse case
  always @(posedge clock) if (in_hw_powerdown === 1'b1) pd_seen <= 1'b1;
  // counts reload pulses: a one-cycle pulse is easy to miss at a later check
  always @(posedge clock) if (wdt_reload === 1'b1) n_reload++;

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask

  // bounded wait: 0 power down, 1 internal reset, 2 osc fail, 3 main clock selected
  task automatic wait_for(input int sel, input logic v);
    int i;
    logic s;
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      s = sel == 0 ? in_hw_powerdown : sel == 1 ? internal_reset :
          sel == 2 ? osc_fail_flag : clk_sel_main;
      if (s === v) break;
    end
    check(i < 400, 1'b1, "wait timed out");
  endtask

  task automatic results;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // whole sequence needs well under 2000 clocks
  initial begin
    #100000;
    error_cnt++;
    results();
  end

  initial begin
    step(12);
    rst_n = 1'b1;
    step(1);
    powersave_enable_autowdt_pin = 1'b0;
    wait_for(1, 1'b0);
    check(autowdt_strap, 1'b1, "strap");
    check(wdt_run, 1'b1, "autostart");
    check(sw_powersave_allowed, 1'b1, "sw saving");
    check(n_reload == 1, 1'b1, "reload pulse");
    check(wdt_reload, 1'b0, "reload one cycle");
    step(1);
    wdt_overflow = 1'b1;
    step(1);
    wdt_overflow = 1'b0;
    step(1);
    check(wdt_status_flag, 1'b1, "wdt flag");
    // one low sample only: reset then run again
    pd_seen = 1'b0;
    sup.set(1'b0, 1'b1, 1'b1);
    step(MC - 1);
    sup.set(1'b1, 1'b1, 1'b1);
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    check(pd_seen, 1'b0, "short pulse");
    check(wdt_run, 1'b0, "wdt stopped");
    check(wdt_status_flag, 1'b0, "wdt flag");
    // full power down with the boot pin high
    boot_program_enable_pin = 1'b1;
    sup.set(1'b0, 1'b1, 1'b1);
    wait_for(0, 1'b1);
    step(8 * MC);
    check(in_hw_powerdown, 1'b1, "held down");
    check(port_oe_n, 1'b1, "ports float");
    check(strobe_oe_n, 1'b1, "strobes float");
    check(port_input_en, 1'b0, "inputs off");
    check(powersave_pullup_en, 1'b0, "ps pull-up");
    check(owe_pullup_en, 1'b0, "owe pull-up");
    check(main_osc_en, 1'b0, "main osc off");
    check(rc_osc_en, 1'b0, "rc osc off");
    check(sw_powersave_allowed, 1'b0, "sw saving");
    sup.set(1'b1, 1'b1, 1'b1);
    wait_for(2, 1'b1);
    check(port_oe_n, 1'b0, "ports driven");
    check(port_input_en, 1'b1, "inputs on");
    check(main_osc_en, 1'b1, "main osc on");
    check(rc_osc_en, 1'b1, "rc osc on");
    check(internal_reset, 1'b1, "held in reset");
    check(bootstrap_mode_flag, 1'b1, "boot flag");
    step(4);
    check(clk_sel_main, 1'b0, "rc clock");
    check(rc_clk_gate, 1'b1, "rc gate");
    wait_for(1, 1'b0);
    check(osc_status_flag, 1'b1, "osc status");
    check(wdt_run, 1'b1, "restart wdt");
    check(n_reload == 2, 1'b1, "restart reload");
    wait_for(3, 1'b1);
    step(4);
    check(rc_clk_gate, 1'b0, "rc gate off");
    check(main_clk_gate, 1'b1, "main gate");
    // boot rom window top edge
    code_addr = 16'h01FF;
    step(2);
    check(boot_rom_select, 1'b1, "rom top");
    code_addr = 16'h0200;
    step(2);
    check(boot_rom_select, 1'b0, "rom past");
    // clock enable low freezes every flop, the status clear included
    ce = 1'b0;
    code_addr = 16'h01FF;
    osc_status_clr = 1'b1;
    step(3);
    check(boot_rom_select, 1'b0, "frozen select");
    check(osc_status_flag, 1'b1, "frozen status");
    ce = 1'b1;
    step(1);
    osc_status_clr = 1'b0;
    check(osc_status_flag, 1'b0, "osc status clear");
    step(1);
    check(boot_rom_select, 1'b1, "thawed select");
    // reset pin during power down, boot pin low at its release
    boot_program_enable_pin = 1'b0;
    sup.set(1'b0, 1'b1, 1'b1);
    wait_for(0, 1'b1);
    sup.set(1'b0, 1'b0, 1'b1);
    step(3);
    check(in_hw_powerdown, 1'b0, "reset wins");
    check(internal_reset, 1'b1, "reset on");
    sup.set(1'b1, 1'b0, 1'b1);
    sup.set(1'b1, 1'b1, 1'b1);
    wait_for(1, 1'b0);
    check(bootstrap_mode_flag, 1'b0, "no boot");
    check(autowdt_strap, 1'b0, "strap relatch");
    check(n_reload == 2, 1'b1, "no autostart");
    // restart with the enable strap low never gets going
    sup.set(1'b0, 1'b1, 1'b1);
    wait_for(0, 1'b1);
    sup.set(1'b0, 1'b1, 1'b0);
    sup.set(1'b1, 1'b1, 1'b0);
    wait_for(2, 1'b1);
    step(40);
    check(main_osc_en, 1'b0, "owe low main");
    check(rc_osc_en, 1'b0, "owe low rc");
    check(internal_reset, 1'b1, "stuck");
    sup.set(1'b1, 1'b0, 1'b1);
    sup.set(1'b1, 1'b1, 1'b1);
    wait_for(1, 1'b0);
    results();
  end
endmodule
